// File: hw/gpd_cfg.svh
`ifndef GPD_CFG_SVH
`define GPD_CFG_SVH

// ----------------------------------------------------------------
// bus geometry and answers
// ----------------------------------------------------------------
`define GPD_ADDR_W      12
`define GPD_IDX_W       10
`define GPD_RESP_OKAY   2'h0
`define GPD_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GPD_IDX_D_LATCH 10'h003
`define GPD_IDX_D_DIR   10'h007
`define GPD_IDX_E_LATCH 10'h008
`define GPD_IDX_F_LATCH 10'h009
`define GPD_IDX_E_DIR   10'h00C
`define GPD_IDX_F_DIR   10'h00D
`define GPD_IDX_FSEL    10'h010

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPD_DIR_D_RST   8'h00
`define GPD_DIR_E_RST   8'h00
`define GPD_DIR_F_RST   7'h00
`define GPD_FSEL_RST    14'h0000

// ----------------------------------------------------------------
// function select field positions
// ----------------------------------------------------------------
`define GPD_FS_SPI_EN   0
`define GPD_FS_SPI_MST  1
`define GPD_FS_MODF_EN  2
`define GPD_FS_SER_EN   3
`define GPD_FS_TA_LSB   4
`define GPD_FS_TB_LSB   10
`define GPD_FS_TA_CLK   12
`define GPD_FS_TB_CLK   13

`endif

// File: hw/gpd_pkg.sv
`include "gpd_cfg.svh"

package gpd_pkg;

  typedef struct packed {
    logic                   awvalid;
    logic [`GPD_ADDR_W-1:0] awaddr;
    logic                   wvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [`GPD_ADDR_W-1:0] araddr;
    logic                   rready;
  } gpd_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } gpd_axi_rsp_type;

  // msb first, so spiEnable lands on bit 0
  typedef struct packed {
    logic       tbExtClk;
    logic       taExtClk;
    logic [1:0] tbChan;
    logic [5:0] taChan;
    logic       serialEn;
    logic       modeFault;
    logic       spiMaster;
    logic       spiEnable;
  } gpd_fsel_type;

  typedef struct packed {
    logic [7:0] dOut;
    logic [7:0] dOe;
    logic [7:0] eOut;
    logic [7:0] eOe;
    logic [6:0] fOut;
    logic [6:0] fOe;
  } gpd_pin_drv_type;

  typedef struct packed {
    logic [7:0] eOut;
    logic [7:0] eOe;
    logic [6:0] fOut;
    logic [6:0] fOe;
  } gpd_periph_type;

  typedef struct packed {
    logic                   awGot;
    logic [`GPD_ADDR_W-1:0] awAddr;
    logic                   wGot;
    logic [31:0]            wData;
    logic [3:0]             wStrb;
    gpd_axi_rsp_type        rsp;
    logic [7:0]             latchD;
    logic [7:0]             latchE;
    logic [6:0]             latchF;
    logic [7:0]             dirD;
    logic [7:0]             dirE;
    logic [6:0]             dirF;
    gpd_fsel_type           fsel;
    gpd_pin_drv_type        pins;
  } gpd_state_type;

endpackage

// File: hw/gpd_sync.sv
`timescale 1ns/1ns

module gpd_sync
  import gpd_pkg::*;
#(
  parameter int W = 23
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } gpd_sync_state_type;

  gpd_sync_state_type state;
  gpd_sync_state_type next_state;

  if (W < 1) begin : g_chk
    $error("gpd_sync: width must be at least one");
  end

  // stage1 feeds stage2 only
  always_comb begin
    next_state.stage1 = async;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign synced = state.stage2;

endmodule

// File: hw/gpd_pin_mux.sv
`timescale 1ns/1ns

module gpd_pin_mux
  import gpd_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] ovr,
  input  wire logic [W-1:0] periphOe,
  input  wire logic [W-1:0] periphOut,
  input  wire logic [W-1:0] pinLevel,
  output logic      [W-1:0] drvOe,
  output logic      [W-1:0] drvOut,
  output logic      [W-1:0] readback
);

  if (W < 1 || W > 8) begin : g_chk
    $error("gpd_pin_mux: width must be 1 to 8");
  end

  always_comb begin
    // R22: owner takes drive
    drvOe    = (ovr & periphOe) | (~ovr & dir);
    drvOut   = (ovr & periphOut) | (~ovr & latch);
    // R4 R6 R20: dir picks readback
    readback = (dir & latch) | (~dir & pinLevel);
  end

endmodule

// File: hw/gpd_gpio_top.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns

// How it works
// R1: direction one drives pin, zero floats
// R2: reset clears port D directions
// R3: software loads latch before enabling output
// R4: port D read mixes latch, pin
// R5: latch writes always land
// R6: port E read mixes latch, pin
// R7: reset clears port E directions
// R8: E7 is SPI clock when enabled
// R9: E6, E5 are SPI data when enabled
// R10: E4 slave select unless disabled/master-no-fault
// R11: slave mode ignores E4 direction
// R12: owned E pins ignore direction drive
// R13: E3, E2 follow timer A channels
// R14: E1, E0 serial while serial enabled
// R15: port F seven bits, latch keeps reset
// R16: F3..F0 follow timer A channels 5..2
// R17: F5, F4 follow timer B channels
// R18: owned F pins ignore direction drive
// R19: reset clears port F directions
// R20: port F read mixes latch, pin
// R21: D timer clock pins ignore direction
// R22: owner drives pin while override active
module gpd_gpio_top
  import gpd_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire gpd_axi_req_type axiReq,
  output gpd_axi_rsp_type      axiRsp,
  input  wire logic [7:0]      portDPin,
  input  wire logic [7:0]      portEPin,
  input  wire logic [6:0]      portFPin,
  output gpd_pin_drv_type      pinDrv,
  input  wire gpd_periph_type  periph,
  output logic [22:0]          pinLevel,
  output gpd_fsel_type         fselOut
);

  // ----------------------------------------------------------------
  // state and pin sampling
  // ----------------------------------------------------------------
  gpd_state_type   state;
  gpd_state_type   next_state;
  logic [22:0]     pinSync;
  logic [7:0]      pinD;
  logic [7:0]      pinE;
  logic [6:0]      pinF;
  logic [7:0]      ovrD;
  logic [7:0]      ovrE;
  logic [6:0]      ovrF;
  logic [7:0]      oeD;
  logic [7:0]      outD;
  logic [7:0]      rdD;
  logic [7:0]      oeE;
  logic [7:0]      outE;
  logic [7:0]      rdE;
  logic [6:0]      oeF;
  logic [6:0]      outF;
  logic [6:0]      rdF;
  logic [`GPD_IDX_W-1:0] wrIdx;
  logic [`GPD_IDX_W-1:0] rdIdx;

  gpd_sync #(
    .W (23)
  ) u_sync (
    .clk    (clk),
    .async  ({portDPin, portEPin, portFPin}),
    .synced (pinSync)
  );

  assign pinD = pinSync[22:15];
  assign pinE = pinSync[14:7];
  assign pinF = pinSync[6:0];

  // ----------------------------------------------------------------
  // peripheral takeover
  // ----------------------------------------------------------------
  always_comb begin
    // R21: timer clock inputs
    ovrD    = 8'h00;
    ovrD[6] = state.fsel.taExtClk;
    ovrD[4] = state.fsel.tbExtClk;
    // R8: serial clock pin
    ovrE[7] = state.fsel.spiEnable;
    // R9: spi data pins
    ovrE[6] = state.fsel.spiEnable;
    ovrE[5] = state.fsel.spiEnable;
    // R10 R11: slave select use
    ovrE[4] = state.fsel.spiEnable &&
              !(state.fsel.spiMaster && !state.fsel.modeFault);
    // R13: timer A ch1, ch0
    ovrE[3:2] = state.fsel.taChan[1:0];
    // R14: serial rx, tx
    ovrE[1:0] = {2{state.fsel.serialEn}};
    // R16: timer A ch5..ch2
    ovrF[3:0] = state.fsel.taChan[5:2];
    // R17: timer B ch1, ch0
    ovrF[5:4] = state.fsel.tbChan;
    ovrF[6]   = 1'b0;
  end

  // timer clock pins are inputs only, so no peripheral drive on D
  gpd_pin_mux #(
    .W (8)
  ) u_mux_d (
    .dir       (state.dirD),
    .latch     (state.latchD),
    .ovr       (ovrD),
    .periphOe  (8'h00),
    .periphOut (8'h00),
    .pinLevel  (pinD),
    .drvOe     (oeD),
    .drvOut    (outD),
    .readback  (rdD)
  );

  gpd_pin_mux #(
    .W (8)
  ) u_mux_e (
    .dir       (state.dirE),
    .latch     (state.latchE),
    .ovr       (ovrE),
    .periphOe  (periph.eOe),
    .periphOut (periph.eOut),
    .pinLevel  (pinE),
    .drvOe     (oeE),
    .drvOut    (outE),
    .readback  (rdE)
  );

  gpd_pin_mux #(
    .W (7)
  ) u_mux_f (
    .dir       (state.dirF),
    .latch     (state.latchF),
    .ovr       (ovrF),
    .periphOe  (periph.fOe),
    .periphOut (periph.fOut),
    .pinLevel  (pinF),
    .drvOe     (oeF),
    .drvOut    (outF),
    .readback  (rdF)
  );

  // ----------------------------------------------------------------
  // bus slave and registers
  // ----------------------------------------------------------------
  assign wrIdx = state.awAddr[`GPD_ADDR_W-1:2];
  assign rdIdx = axiReq.araddr[`GPD_ADDR_W-1:2];

  always_comb begin
    next_state = state;
    if (axiReq.awvalid && state.rsp.awready) begin
      next_state.awGot  = 1'b1;
      next_state.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && state.rsp.wready) begin
      next_state.wGot  = 1'b1;
      next_state.wData = axiReq.wdata;
      next_state.wStrb = axiReq.wstrb;
    end
    if (axiReq.bready && state.rsp.bvalid) begin
      next_state.rsp.bvalid = 1'b0;
    end
    // address and data may arrive in either order; commit once both held
    if (next_state.awGot && next_state.wGot) begin
      next_state.awGot     = 1'b0;
      next_state.wGot      = 1'b0;
      next_state.rsp.bvalid = 1'b1;
      next_state.rsp.bresp  = `GPD_RESP_OKAY;
      unique case (next_state.awAddr[`GPD_ADDR_W-1:2])
        // R5: latch writes regardless of direction
        `GPD_IDX_D_LATCH: if (next_state.wStrb[0]) next_state.latchD = next_state.wData[7:0];
        `GPD_IDX_E_LATCH: if (next_state.wStrb[0]) next_state.latchE = next_state.wData[7:0];
        `GPD_IDX_F_LATCH: if (next_state.wStrb[0]) next_state.latchF = next_state.wData[6:0];
        `GPD_IDX_D_DIR:   if (next_state.wStrb[0]) next_state.dirD = next_state.wData[7:0];
        `GPD_IDX_E_DIR:   if (next_state.wStrb[0]) next_state.dirE = next_state.wData[7:0];
        `GPD_IDX_F_DIR:   if (next_state.wStrb[0]) next_state.dirF = next_state.wData[6:0];
        `GPD_IDX_FSEL: begin
          if (next_state.wStrb[0]) next_state.fsel[7:0] = next_state.wData[7:0];
          if (next_state.wStrb[1]) next_state.fsel[13:8] = next_state.wData[13:8];
        end
        default: next_state.rsp.bresp = `GPD_RESP_SLVERR;
      endcase
    end
    next_state.rsp.awready = !next_state.awGot && !next_state.rsp.bvalid;
    next_state.rsp.wready  = !next_state.wGot && !next_state.rsp.bvalid;

    if (axiReq.rready && state.rsp.rvalid) begin
      next_state.rsp.rvalid = 1'b0;
    end
    if (axiReq.arvalid && state.rsp.arready) begin
      next_state.rsp.rvalid = 1'b1;
      next_state.rsp.rdata  = 32'h0000_0000;
      next_state.rsp.rresp  = `GPD_RESP_OKAY;
      unique case (rdIdx)
        // R4: port D readback
        `GPD_IDX_D_LATCH: next_state.rsp.rdata[7:0] = rdD;
        // R6: port E readback
        `GPD_IDX_E_LATCH: next_state.rsp.rdata[7:0] = rdE;
        // R20: port F readback
        `GPD_IDX_F_LATCH: next_state.rsp.rdata[6:0] = rdF;
        `GPD_IDX_D_DIR:   next_state.rsp.rdata[7:0] = state.dirD;
        `GPD_IDX_E_DIR:   next_state.rsp.rdata[7:0] = state.dirE;
        `GPD_IDX_F_DIR:   next_state.rsp.rdata[6:0] = state.dirF;
        `GPD_IDX_FSEL:    next_state.rsp.rdata[13:0] = state.fsel;
        default:          next_state.rsp.rresp = `GPD_RESP_SLVERR;
      endcase
    end
    next_state.rsp.arready = !next_state.rsp.rvalid;

    // R1: registered pin drive
    next_state.pins.dOe  = oeD;
    next_state.pins.dOut = outD;
    next_state.pins.eOe  = oeE;
    next_state.pins.eOut = outE;
    next_state.pins.fOe  = oeF;
    next_state.pins.fOut = outF;

    if (srst) begin
      next_state.awGot = 1'b0;
      next_state.wGot  = 1'b0;
      next_state.rsp   = '0;
      // R2: port D inputs
      next_state.dirD  = `GPD_DIR_D_RST;
      // R7: port E inputs
      next_state.dirE  = `GPD_DIR_E_RST;
      // R19: port F inputs
      next_state.dirF  = `GPD_DIR_F_RST;
      next_state.fsel  = `GPD_FSEL_RST;
      next_state.pins  = '0;
      // R15: latches left as they were
      next_state.latchD = state.latchD;
      next_state.latchE = state.latchE;
      next_state.latchF = state.latchF;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign axiRsp   = state.rsp;
  assign pinDrv   = state.pins;
  assign pinLevel = pinSync;
  assign fselOut  = state.fsel;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic arTake;
  logic wrBoth;
  assign arTake = axiReq.arvalid && state.rsp.arready;
  assign wrBoth = axiReq.awvalid && state.rsp.awready && axiReq.wvalid && state.rsp.wready;

  // watch only: latches power up unknown, so the drive and reset-keep checks wait for a first write; the read-mix checks do not
  logic [2:0] latchWritten = 3'h0;
  always_ff @(posedge clk) begin
    if (state.rsp.bvalid && state.wStrb[0]) begin
      if (wrIdx == `GPD_IDX_D_LATCH) begin
        latchWritten[0] <= 1'b1;
      end
      if (wrIdx == `GPD_IDX_E_LATCH) begin
        latchWritten[1] <= 1'b1;
      end
      if (wrIdx == `GPD_IDX_F_LATCH) begin
        latchWritten[2] <= 1'b1;
      end
    end
  end

  a_dir_d_reset: assert property ($past(srst) |-> state.dirD == 8'h00 && pinDrv.dOe == 8'h00) // R2
    else $error("port D direction not cleared by reset");
  a_dir_e_reset: assert property ($past(srst) |-> state.dirE == 8'h00 && pinDrv.eOe == 8'h00) // R7
    else $error("port E direction not cleared by reset");
  a_dir_f_reset: assert property ($past(srst) |-> state.dirF == 7'h00 && pinDrv.fOe == 7'h00) // R19
    else $error("port F direction not cleared by reset");
  a_latch_f_keep: assert property (@(posedge clk) disable iff (1'b0) // R15
      latchWritten[2] && srst |=> state.latchF == $past(state.latchF))
    else $error("port F latch changed by reset");
  a_d_plain_drive: assert property ($past(!srst) && latchWritten[0] |-> // R1
      pinDrv.dOe == ($past(state.dirD) & ~$past(ovrD)) &&
      pinDrv.dOut == ($past(state.latchD) & ~$past(ovrD)))
    else $error("port D drive does not follow direction and latch");
  a_d_clk_input: assert property (state.fsel.taExtClk && state.dirD[6] |=> !pinDrv.dOe[6]) // R21
    else $error("timer clock pin driven despite selection");
  a_d_read_mix: assert property (arTake && rdIdx == `GPD_IDX_D_LATCH |=> // R4
      axiRsp.rvalid &&
      axiRsp.rdata[7:0] == $past((state.latchD & state.dirD) | (pinD & ~state.dirD)))
    else $error("port D read returned wrong mix");
  a_e_read_mix: assert property (arTake && rdIdx == `GPD_IDX_E_LATCH |=> // R6
      axiRsp.rvalid &&
      axiRsp.rdata[7:0] == $past((state.latchE & state.dirE) | (pinE & ~state.dirE)))
    else $error("port E read returned wrong mix");
  a_f_read_mix: assert property (arTake && rdIdx == `GPD_IDX_F_LATCH |=> // R20
      axiRsp.rvalid &&
      axiRsp.rdata[6:0] == $past((state.latchF & state.dirF) | (pinF & ~state.dirF)))
    else $error("port F read returned wrong mix");
  a_latch_write: assert property (wrBoth && axiReq.wstrb[0] && // R5
      axiReq.awaddr[`GPD_ADDR_W-1:2] == `GPD_IDX_E_LATCH |=>
      state.latchE == $past(axiReq.wdata[7:0]) && axiRsp.bvalid)
    else $error("port E latch write lost");
  a_spi_clk_owner: assert property (state.fsel.spiEnable |=> // R8
      pinDrv.eOe[7] == $past(periph.eOe[7]) && pinDrv.eOut[7] == $past(periph.eOut[7]))
    else $error("spi clock pin not driven by spi");
  a_spi_data_owner: assert property (state.fsel.spiEnable |=> // R9
      pinDrv.eOe[6:5] == $past(periph.eOe[6:5]))
    else $error("spi data pins not owned by spi");
  a_ss_plain_io: assert property (state.fsel.spiEnable && state.fsel.spiMaster && // R10
      !state.fsel.modeFault |=> pinDrv.eOe[4] == $past(state.dirE[4]))
    else $error("slave select not plain io in master without fault");
  a_ss_slave_dir: assert property (state.fsel.spiEnable && !state.fsel.spiMaster |=> // R11
      pinDrv.eOe[4] == $past(periph.eOe[4]))
    else $error("slave select drive follows direction in slave mode");
  a_timer_e_owner: assert property (state.fsel.taChan[1:0] == 2'h3 |=> // R13
      pinDrv.eOe[3:2] == $past(periph.eOe[3:2]))
    else $error("timer A pins on port E not owned");
  a_serial_off: assert property (!state.fsel.serialEn && latchWritten[1] |=> // R14
      pinDrv.eOe[1:0] == $past(state.dirE[1:0]) &&
      pinDrv.eOut[1:0] == $past(state.latchE[1:0]))
    else $error("serial pins not plain io while disabled");
  a_e_owned_dir: assert property (ovrE != 8'h00 && $changed(state.dirE) |=> // R12
      (pinDrv.eOe & $past(ovrE)) == ($past(periph.eOe) & $past(ovrE)))
    else $error("direction leaked into owned port E pin");
  a_timer_f_owner: assert property (state.fsel.taChan[5:2] == 4'hF |=> // R16
      pinDrv.fOe[3:0] == $past(periph.fOe[3:0]))
    else $error("timer A pins on port F not owned");
  a_timer_b_owner: assert property (state.fsel.tbChan == 2'h3 |=> // R17
      pinDrv.fOut[5:4] == $past(periph.fOut[5:4]))
    else $error("timer B pins on port F not owned");
  a_f_owned_dir: assert property ($past(!srst) |-> pinDrv.fOe == // R18
      (($past(ovrF) & $past(periph.fOe)) | (~$past(ovrF) & $past(state.dirF))))
    else $error("port F drive selection wrong");
  a_owner_drive: assert property ($past(!srst) && latchWritten[1] |-> // R22
      pinDrv.eOut ==
      (($past(ovrE) & $past(periph.eOut)) | (~$past(ovrE) & $past(state.latchE))))
    else $error("port E output selection wrong");

  c_write_then_resp: cover property (wrBoth ##1 axiRsp.bvalid && axiReq.bready);
  c_read_input_pin: cover property (arTake && rdIdx == `GPD_IDX_E_LATCH && state.dirE != 8'hFF);
  c_spi_slave_mode: cover property (state.fsel.spiEnable && !state.fsel.spiMaster ##1
      pinDrv.eOe[4] == 1'b1);
  c_timer_clk_pin: cover property (state.fsel.taExtClk && state.dirD[6]);
  c_owned_dir_move: cover property (ovrE != 8'h00 && $changed(state.dirE));

endmodule

// File: dv/gpd_pin_model.sv
`timescale 1ns/1ns

module gpd_pin_model
  import gpd_pkg::*;
(
  input  wire logic            clk,
  input  wire gpd_pin_drv_type pinDrv,
  input  wire logic [22:0]     extOe,
  input  wire logic [22:0]     extVal,
  output logic [7:0]           portDPin,
  output logic [7:0]           portEPin,
  output logic [6:0]           portFPin
);
  logic [22:0] floatPat = 23'h2AAAAA;
  logic [22:0] oe;
  logic [22:0] drv;

  // undriven pins wander so a stale level is never read as valid
  always_ff @(posedge clk) begin
    floatPat <= ~floatPat;
  end

  assign oe  = {pinDrv.dOe, pinDrv.eOe, pinDrv.fOe};
  assign drv = {pinDrv.dOut, pinDrv.eOut, pinDrv.fOut};
  assign {portDPin, portEPin, portFPin} = (oe & drv) | (~oe & extOe & extVal)
                                        | (~oe & ~extOe & floatPat);
endmodule

// File: dv/tb_gpio_ports_d_e_f.sv
`timescale 1ns/1ns
`include "gpd_cfg.svh"

module tb_gpio_ports_d_e_f
  import gpd_pkg::*;
;
  typedef struct packed {
    logic [1:0] port;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] ext;
  } gpd_row_type;

  logic            clk;
  logic            srst;
  gpd_axi_req_type req;
  gpd_axi_rsp_type rsp;
  logic [7:0]      portDPin;
  logic [7:0]      portEPin;
  logic [6:0]      portFPin;
  gpd_pin_drv_type pd;
  gpd_periph_type  periph;
  gpd_fsel_type    fselOut;
  logic [22:0]     extOe;
  logic [22:0]     extVal;
  logic [22:0]     lvl;
  int              n_errors;
  int              checks;
  logic [9:0]      latIdx [3] = '{`GPD_IDX_D_LATCH, `GPD_IDX_E_LATCH, `GPD_IDX_F_LATCH};
  logic [9:0]      dirIdx [3] = '{`GPD_IDX_D_DIR, `GPD_IDX_E_DIR, `GPD_IDX_F_DIR};
  int              shiftOf [3] = '{15, 7, 0};
  gpd_row_type     rows [4] = '{
    '{2'd0, 8'hA5, 8'hF0, 8'h3C}, '{2'd1, 8'h5A, 8'h0F, 8'hC3},
    '{2'd2, 8'h7F, 8'h55, 8'h2A}, '{2'd0, 8'h00, 8'hFF, 8'hFF}};
  logic [13:0]     fselList [8] = '{14'h0001, 14'h0003, 14'h0007, 14'h0008,
                                    14'h03F0, 14'h0C00, 14'h3000, 14'h0000};

  gpd_gpio_top u_dut (
    .clk      (clk),
    .srst     (srst),
    .axiReq   (req),
    .axiRsp   (rsp),
    .portDPin (portDPin),
    .portEPin (portEPin),
    .portFPin (portFPin),
    .pinDrv   (pd),
    .periph   (periph),
    .pinLevel (lvl),
    .fselOut  (fselOut)
  );

  gpd_pin_model u_pins (
    .clk      (clk),
    .pinDrv   (pd),
    .extOe    (extOe),
    .extVal   (extVal),
    .portDPin (portDPin),
    .portEPin (portEPin),
    .portFPin (portFPin)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic a;
    logic w;
    n = 0;
    a = 1'b1;
    w = 1'b1;
    r = 2'h3;
    req.awaddr <= {idx, 2'h0};
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (!a && !w && rsp.bvalid === 1'b1) break;
      if (a && rsp.awready === 1'b1) begin
        a = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    r = rsp.bresp;
    if (n >= 100) chk("write_wait", 32'h1, 32'h0);
  endtask

  task automatic axi_rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic a;
    n = 0;
    a = 1'b1;
    req.araddr <= {idx, 2'h0};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (!a && rsp.rvalid === 1'b1) break;
      if (a && rsp.arready === 1'b1) begin
        a = 1'b0;
        req.arvalid <= 1'b0;
      end
    end
    d = rsp.rdata;
    r = rsp.rresp;
    if (n >= 100) chk("read_wait", 32'h1, 32'h0);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic reset_values();
    logic [31:0] d;
    logic [1:0]  r;
    for (int p = 0; p < 3; p++) begin
      axi_rd(dirIdx[p], d, r);
      chk("dir_reset", 32'h0, d);
    end
    axi_rd(`GPD_IDX_FSEL, d, r);
    chk("fsel_reset", 32'h0, d);
    chk("oe_reset", 32'h0, {pd.dOe, pd.eOe, pd.fOe});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  m;
    logic [7:0]  ownE;
    logic [6:0]  ownF;
    logic [7:0]  eOe;
    logic [6:0]  fOe;
    logic [13:0] f;
    logic [22:0] drvn;
    req = '0;
    periph = '{eOut: 8'hC3, eOe: 8'h5A, fOut: 7'h55, fOe: 7'h2A};
    extOe = '0;
    extVal = '0;
    n_errors = 0;
    checks = 0;
    do_reset();
    reset_values();
    foreach (rows[i]) begin
      m = (rows[i].port == 2'd2) ? 8'h7F : 8'hFF;
      axi_wr(latIdx[rows[i].port], {24'h0, rows[i].latch}, r);
      axi_wr(dirIdx[rows[i].port], {24'h0, rows[i].dir}, r);
      extVal <= 23'({rows[i].ext & m} << shiftOf[rows[i].port]);
      extOe <= 23'({~rows[i].dir & m} << shiftOf[rows[i].port]);
      repeat (4) @(posedge clk);
      axi_rd(latIdx[rows[i].port], d, r);
      chk("port_read", {24'h0, m & ((rows[i].latch & rows[i].dir)
          | (rows[i].ext & ~rows[i].dir))}, d);
      drvn = {pd.dOe, pd.eOe, pd.fOe} | extOe;
      chk("pin_level", {9'h0, drvn & {portDPin, portEPin, portFPin}},
          {9'h0, drvn & lvl});
      d = {pd.dOe, pd.eOe, pd.fOe} >> shiftOf[rows[i].port];
      chk("pin_oe", {24'h0, rows[i].dir & m}, {24'h0, d[7:0] & m});
    end
    // peripheral ownership with every direction bit set
    extOe <= '0;
    for (int p = 0; p < 3; p++) begin
      axi_wr(latIdx[p], 32'h0F, r);
      axi_wr(dirIdx[p], 32'hFF, r);
    end
    foreach (fselList[i]) begin
      f = fselList[i];
      axi_wr(`GPD_IDX_FSEL, {18'h0, f}, r);
      repeat (3) @(posedge clk);
      ownE = {f[0], f[0], f[0], f[0] & ~(f[1] & ~f[2]), f[5:4], f[3], f[3]};
      ownF = {1'b0, f[11:10], f[9:6]};
      eOe = (ownE & 8'h5A) | ~ownE;
      fOe = (ownF & 7'h2A) | ~ownF;
      chk("fsel_out", {18'h0, f}, {18'h0, fselOut});
      chk("e_oe", {24'h0, eOe}, {24'h0, pd.eOe});
      chk("e_out", {24'h0, eOe & ((ownE & 8'hC3) | (~ownE & 8'h0F))},
          {24'h0, eOe & pd.eOut});
      chk("f_oe", {25'h0, fOe}, {25'h0, pd.fOe});
      chk("f_out", {25'h0, fOe & ((ownF & 7'h55) | (~ownF & 7'h0F))},
          {25'h0, fOe & pd.fOut});
      chk("d_oe", {24'h0, ~{1'b0, f[12], 1'b0, f[13], 4'h0}}, {24'h0, pd.dOe});
      axi_rd(`GPD_IDX_E_LATCH, d, r);
      chk("e_read_owned", 32'h0F, d);
      axi_rd(`GPD_IDX_F_LATCH, d, r);
      chk("f_read_owned", 32'h0F, d);
    end
    // direction change while spi slave owns E7..E4
    axi_wr(`GPD_IDX_FSEL, 32'h1, r);
    axi_wr(dirIdx[1], 32'h0F, r);
    repeat (3) @(posedge clk);
    chk("e_oe_owned_dir", 32'h5F, {24'h0, pd.eOe});
    // unmapped place
    axi_wr(10'h3FF, 32'hFFFF_FFFF, r);
    chk("unmapped_bresp", {30'h0, `GPD_RESP_SLVERR}, {30'h0, r});
    axi_rd(10'h3FF, d, r);
    chk("unmapped_rresp", {30'h0, `GPD_RESP_SLVERR}, {30'h0, r});
    chk("unmapped_rdata", 32'h0, d);
    // second reset keeps the port F latch
    do_reset();
    reset_values();
    axi_wr(`GPD_IDX_F_DIR, 32'h7F, r);
    axi_rd(`GPD_IDX_F_LATCH, d, r);
    chk("f_latch_kept", 32'h0F, d);
    print_verdict();
  end

  initial begin
    #500000;
    n_errors++;
    print_verdict();
  end
endmodule
